// ===== hdl/ext_bus_cs_pkg.sv
// Purpose: shared constants and types of the chip-select and ALE control
// Assumes: sys_clk at 40 MHz, one sys_clk is half a CPU clock
// Notes:   config word per window, window word per programmable window
package ext_bus_cs_pkg;

	localparam int N_CS        = 5;
	localparam int N_WIN       = 4;
	localparam int ADDR_W      = 24;
	localparam int CNT_W       = 6;

	// two-bit strap encodings for the number of chip select lines
	localparam logic [1:0] STRAP_FIVE  = 2'h3;
	localparam logic [1:0] STRAP_NONE  = 2'h2;
	localparam logic [1:0] STRAP_TWO   = 2'h1;
	localparam logic [1:0] STRAP_THREE = 2'h0;
	localparam logic [4:0] LINES_FIVE  = 5'h1F;
	localparam logic [4:0] LINES_NONE  = 5'h00;
	localparam logic [4:0] LINES_TWO   = 5'h03;
	localparam logic [4:0] LINES_THREE = 5'h07;

	// bus_config_reg layout
	localparam int CFG_W        = 10;
	localparam int CFG_RDEN_BIT = 0;  // cs_read_enable
	localparam int CFG_WREN_BIT = 1;  // cs_write_enable
	localparam int CFG_ALE_BIT  = 2;  // ale_stretch
	localparam int CFG_TRI_BIT  = 3;  // 1: insert tri-state wait state
	localparam int CFG_RWD_BIT  = 4;  // 1: delay command half a CPU clock
	localparam int CFG_RDY_BIT  = 5;  // 1: cycle ended by ready_n
	localparam int CFG_WS_LSB   = 6;  // four-bit wait state count
	localparam int CFG_WS_W     = 4;
	localparam logic [CFG_W-1:0] CFG0_RESET = 10'h3DC;
	localparam logic [CFG_W-1:0] CFGX_RESET = 10'h3D8;

	// addr_window_reg layout: compare acc_addr[23:12] under a mask
	localparam int WIN_W        = 25;
	localparam int WIN_BASE_LSB = 0;
	localparam int WIN_MASK_LSB = 12;
	localparam int WIN_FLD_W    = 12;
	localparam int WIN_EN_BIT   = 24;
	localparam int WIN_ADDR_LSB = 12;
	localparam logic [WIN_W-1:0] WIN_RESET = 25'h0000000;

	// timing: half a CPU clock and its count of sys_clk cycles
	localparam int HALF_CPU_NS  = 25;
	localparam int SYS_CLK_MHZ  = 40;
	localparam int HALF_CPU_RAW = (HALF_CPU_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int HALF_CPU_CYC = (HALF_CPU_RAW < 1) ? 1 : HALF_CPU_RAW;
	localparam int CPU_CLK_CYC  = 2 * HALF_CPU_CYC;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ALE,
		ST_HOLD,
		ST_RWD,
		ST_CMD,
		ST_RDY,
		ST_TRI
	} phase_t;

endpackage : ext_bus_cs_pkg

// ===== hdl/ext_bus_chip_select_ale_ctrl.sv
// Purpose: chip select generation and bus cycle phasing with ALE stretch
// Assumes: all inputs synchronous to sys_clk; ready_n already synchronised
// Notes:   one sys_clk is half a CPU clock; config loaded by write strobes
`timescale 1ns/10ps
module ext_bus_chip_select_ale_ctrl (
	input  wire logic                                sys_clk,
	input  wire logic                                rstn,
	input  wire logic [1:0]                          cs_count_select,
	input  wire logic                                single_chip,
	input  wire logic [ext_bus_cs_pkg::N_CS-1:0]     cfg_we,
	input  wire logic [ext_bus_cs_pkg::CFG_W-1:0]    cfg_wdata,
	input  wire logic [ext_bus_cs_pkg::N_WIN-1:0]    win_we,
	input  wire logic [ext_bus_cs_pkg::WIN_W-1:0]    win_wdata,
	input  wire logic [ext_bus_cs_pkg::N_CS-1:0]     cs_open_drain,
	input  wire logic                                bus_hold_ack,
	input  wire logic                                acc_start,
	input  wire logic [ext_bus_cs_pkg::ADDR_W-1:0]   acc_addr,
	input  wire logic                                acc_write,
	input  wire logic [1:0]                          acc_be,
	input  wire logic                                acc_internal,
	input  wire logic                                ready_n,
	output logic                                     acc_busy,
	output logic                                     acc_done,
	output logic                                     ale,
	output logic                                     read_strobe,
	output logic                                     write_low_strobe,
	output logic                                     write_high_strobe,
	output logic [ext_bus_cs_pkg::N_CS-1:0]          chip_select_n,
	output logic [ext_bus_cs_pkg::N_CS-1:0]          chip_select_oe_n,
	output logic [ext_bus_cs_pkg::N_CS-1:0]          chip_select_pullup,
	output logic [ext_bus_cs_pkg::N_CS-1:0]          cs_lines_active,
	output logic [2:0]                               cur_window
);
	import ext_bus_cs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// configuration storage

	logic [CFG_W-1:0]  bus_config_reg  [0:N_CS-1];
	logic [WIN_W-1:0]  addr_window_reg [0:N_WIN-1];
	logic [N_WIN-1:0]  win_hit;

	genvar gi;
	generate
		// per-window timing and mode; window 0 starts slowest
		for (gi = 0; gi < N_CS; gi++) begin : g_cfg
			always_ff @(posedge sys_clk) begin
				if (!rstn)
					bus_config_reg[gi] <= (gi == 0) ? CFG0_RESET
					                                : CFGX_RESET;
				else if (cfg_we[gi])
					bus_config_reg[gi] <= cfg_wdata;
			end
		end
		// address windows 1..4 with masked compare on the upper bits
		for (gi = 0; gi < N_WIN; gi++) begin : g_win
			always_ff @(posedge sys_clk) begin
				if (!rstn)
					addr_window_reg[gi] <= WIN_RESET;
				else if (win_we[gi])
					addr_window_reg[gi] <= win_wdata;
			end
			assign win_hit[gi] = addr_window_reg[gi][WIN_EN_BIT] &&
				((acc_addr[WIN_ADDR_LSB +: WIN_FLD_W] ^
				  addr_window_reg[gi][WIN_BASE_LSB +: WIN_FLD_W]) &
				 addr_window_reg[gi][WIN_MASK_LSB +: WIN_FLD_W]) == '0;
		end
	endgenerate

	// lowest numbered hit wins; a miss falls back on config zero
	logic [2:0] hit_index;
	assign hit_index = win_hit[0] ? 3'h1 :
	                   win_hit[1] ? 3'h2 :
	                   win_hit[2] ? 3'h3 :
	                   win_hit[3] ? 3'h4 : 3'h0;

	////////////////////////////////////////////////////////////////////////
	// strap latch: taken one clock after release, never under reset

	logic [1:0]      cs_sel_reg;
	logic            strap_done_reg;
	logic [N_CS-1:0] lines_live;
	logic [N_CS-1:0] lines_mask;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			strap_done_reg <= 1'b0;
			cs_sel_reg     <= STRAP_FIVE;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			cs_sel_reg     <= cs_count_select;
		end
	end

	// decode of the strap into enabled lines, live pin and latched copy
	function automatic logic [N_CS-1:0] lines_of(input logic [1:0] sel);
		case (sel)
			STRAP_FIVE: lines_of = LINES_FIVE;
			STRAP_NONE: lines_of = LINES_NONE;
			STRAP_TWO:  lines_of = LINES_TWO;
			default:    lines_of = LINES_THREE;
		endcase
	endfunction : lines_of

	assign lines_live      = lines_of(cs_count_select);
	assign lines_mask      = strap_done_reg ? lines_of(cs_sel_reg)
	                                        : lines_live;
	assign cs_lines_active = lines_mask;

	////////////////////////////////////////////////////////////////////////
	// bus cycle phases

	phase_t           state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [CFG_W-1:0] cfg_cur_reg, cfg_use;
	logic [2:0]       win_reg;
	logic             wr_reg;
	logic [1:0]       be_reg;
	logic             ext_start, int_start, phase_end;

	// internal or single-chip accesses never open an external cycle
	assign ext_start = acc_start && (state_reg == ST_IDLE) &&
	                   !acc_internal && !single_chip;
	assign int_start = acc_start && (state_reg == ST_IDLE) &&
	                   (acc_internal || single_chip);
	assign cfg_use   = (state_reg == ST_IDLE) ? bus_config_reg[hit_index]
	                                          : cfg_cur_reg;
	assign phase_end = (cnt_reg == '0);

	// length of a phase in sys_clk cycles; zero means skipped
	function automatic logic [CNT_W-1:0] phase_len(input phase_t p,
	                                            input logic [CFG_W-1:0] c);
		logic [CFG_WS_W-1:0] ws;
		ws = c[CFG_WS_LSB +: CFG_WS_W];
		if (c[CFG_RDY_BIT])
			ws[CFG_WS_W-1] = 1'b0;
		case (p)
			ST_ALE:  phase_len = CNT_W'(CPU_CLK_CYC +
			             (c[CFG_ALE_BIT] ? HALF_CPU_CYC : 0));
			ST_HOLD: phase_len = c[CFG_ALE_BIT] ? CNT_W'(HALF_CPU_CYC)
			                                    : '0;
			ST_RWD:  phase_len = c[CFG_RWD_BIT] ? CNT_W'(HALF_CPU_CYC)
			                                    : '0;
			ST_CMD:  phase_len = CNT_W'(CPU_CLK_CYC * (1 + int'(ws)));
			ST_RDY:  phase_len = c[CFG_RDY_BIT] ? CNT_W'(1) : '0;
			ST_TRI:  phase_len = c[CFG_TRI_BIT] ? CNT_W'(CPU_CLK_CYC)
			                                    : '0;
			default: phase_len = '0;
		endcase
	endfunction : phase_len

	// successor phase, skipping those of zero length
	function automatic phase_t phase_after(input phase_t p,
	                                       input logic [CFG_W-1:0] c);
		phase_t q;
		q = p;
		for (int k = 0; k < 6; k++) begin
			case (q)
				ST_ALE:  q = ST_HOLD;
				ST_HOLD: q = ST_RWD;
				ST_RWD:  q = ST_CMD;
				ST_CMD:  q = ST_RDY;
				ST_RDY:  q = ST_TRI;
				default: q = ST_IDLE;
			endcase
			if (q == ST_IDLE || phase_len(q, c) != '0)
				break;
		end
		phase_after = q;
	endfunction : phase_after

	// the ready phase holds until ready_n is seen low
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (ext_start) begin
					state_next = ST_ALE;
					cnt_next   = phase_len(ST_ALE, cfg_use) - CNT_W'(1);
				end
			end
			ST_RDY: begin
				if (!ready_n) begin
					state_next = phase_after(ST_RDY, cfg_use);
					cnt_next   = phase_len(state_next, cfg_use) - CNT_W'(1);
				end
			end
			default: begin
				if (phase_end) begin
					state_next = phase_after(state_reg, cfg_use);
					cnt_next   = phase_len(state_next, cfg_use) - CNT_W'(1);
				end else
					cnt_next = cnt_reg - CNT_W'(1);
			end
		endcase
	end

	// state register and per-cycle capture of window and direction
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_reg   <= ST_IDLE;
			cnt_reg     <= '0;
			cfg_cur_reg <= CFG0_RESET;
			win_reg     <= 3'h0;
			wr_reg      <= 1'b0;
			be_reg      <= 2'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (ext_start) begin
				cfg_cur_reg <= bus_config_reg[hit_index];
				win_reg     <= hit_index;
				wr_reg      <= acc_write;
				be_reg      <= acc_be;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// strobes and chip selects from flip-flops; pad enables and pullups combinational

	logic ale_next, cmd_next, ale_fall;
	assign ale_next = (state_next == ST_ALE);
	assign cmd_next = (state_next == ST_CMD) || (state_next == ST_RDY);
	assign ale_fall = (state_reg == ST_ALE) && !ale_next;
	assign acc_busy = (state_reg != ST_IDLE);

	logic [N_CS-1:0] cs_n_next;
	generate
		// address mode swaps at the ALE fall, command modes track strobes
		for (gi = 0; gi < N_CS; gi++) begin : g_cs
			logic rd_en, wr_en, is_mine, cmd_hit;
			assign rd_en   = bus_config_reg[gi][CFG_RDEN_BIT];
			assign wr_en   = bus_config_reg[gi][CFG_WREN_BIT];
			assign is_mine = (win_reg == 3'(gi));
			assign cmd_hit = cmd_next && is_mine &&
			                 ((wr_reg && wr_en) || (!wr_reg && rd_en));
			assign cs_n_next[gi] = !lines_mask[gi] ? 1'b1 :
				(rd_en || wr_en) ? !cmd_hit :
				ale_fall ? !is_mine :
				chip_select_n[gi];
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ale               <= 1'b0;
			read_strobe       <= 1'b0;
			write_low_strobe  <= 1'b0;
			write_high_strobe <= 1'b0;
			acc_done          <= 1'b0;
			cur_window        <= 3'h0;
			chip_select_n     <= '1;
		end else begin
			ale               <= ale_next;
			read_strobe       <= cmd_next && !wr_reg;
			write_low_strobe  <= cmd_next && wr_reg && be_reg[0];
			write_high_strobe <= cmd_next && wr_reg && be_reg[1];
			acc_done          <= int_start || (acc_busy &&
			                     state_next == ST_IDLE);
			cur_window        <= win_reg;
			chip_select_n     <= cs_n_next;
		end
	end

	// pad control: pullups in reset and hold, drive only enabled lines
	assign chip_select_pullup = !rstn ? lines_live :
		bus_hold_ack ? (lines_mask & ~cs_open_drain) : '0;
	assign chip_select_oe_n   = (!rstn || bus_hold_ack) ? '1 :
	                            ~lines_mask;

	////////////////////////////////////////////////////////////////////////
	// checks

	chk_ale_plain_len: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(ale) && !cfg_cur_reg[CFG_ALE_BIT] |-> ale[*2] ##1 !ale)
		else $error("ALE length wrong without stretch");

	chk_ale_stretch_len: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		$rose(ale) && cfg_cur_reg[CFG_ALE_BIT] |-> ale[*3] ##1 !ale)
		else $error("stretched ALE length wrong");

	chk_addr_cs_fall: assert property (@(posedge sys_clk) disable iff (!rstn)
		$fell(ale) && lines_mask[win_reg] &&
		bus_config_reg[win_reg][CFG_WREN_BIT +: 1] == 1'b0 &&
		!bus_config_reg[win_reg][CFG_RDEN_BIT]
		|-> !chip_select_n[win_reg])
		else $error("address select not low after ALE fall");

	chk_cmd_cs_strobe: assert property (@(posedge sys_clk) disable iff (!rstn)
		!chip_select_n[0] && (bus_config_reg[0][CFG_RDEN_BIT] ||
		bus_config_reg[0][CFG_WREN_BIT]) && $stable(bus_config_reg[0])
		|-> read_strobe || write_low_strobe || write_high_strobe)
		else $error("command select without strobe");

	chk_internal_quiet: assert property (@(posedge sys_clk)
		disable iff (!rstn)
		int_start |=> acc_done && !ale && $stable(chip_select_n))
		else $error("internal access touched the bus");

	chk_reset_pullup: assert property (@(posedge sys_clk)
		!rstn |-> chip_select_pullup == lines_live &&
		chip_select_oe_n == '1)
		else $error("pads wrong during reset");

	chk_hold_float: assert property (@(posedge sys_clk) disable iff (!rstn)
		bus_hold_ack |-> chip_select_oe_n == '1 &&
		(chip_select_pullup & cs_open_drain) == '0)
		else $error("pads driven during bus hold");

	chk_cfg_reset_val: assert property (@(posedge sys_clk)
		$past(!rstn) && rstn |-> bus_config_reg[0][CFG_ALE_BIT] &&
		!bus_config_reg[1][CFG_ALE_BIT])
		else $error("ALE stretch reset values wrong");

	chk_unused_lines: assert property (@(posedge sys_clk) disable iff (!rstn)
		!bus_hold_ack |-> (chip_select_oe_n == ~lines_mask) &&
		((~lines_mask & ~chip_select_n) == '0))
		else $error("unselected line not released");

	chk_done_bound: assert property (@(posedge sys_clk) disable iff (!rstn)
		ext_start |-> ##[4:80] acc_done || (state_reg == ST_RDY))
		else $error("external cycle length out of range");

endmodule : ext_bus_chip_select_ale_ctrl

// ===== tb/ext_mem_partner.sv
// Purpose: far-side memory or peripheral answering with ready_n
// Assumes: ready_n idles high through the board pull-up
// Notes:   slow or prompt answer chosen by ready_delay
`timescale 1ns/10ps
module ext_mem_partner (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       cmd_active,
	input  wire logic [3:0] ready_delay,
	output logic            ready_n
);
	logic [4:0] cmd_cnt_reg;

	// count command cycles; drop ready when the command ends
	always_ff @(posedge sys_clk) begin
		if (!rstn || !cmd_active)
			cmd_cnt_reg <= 5'h00;
		else if (cmd_cnt_reg != 5'h1F)
			cmd_cnt_reg <= cmd_cnt_reg + 5'h01;
	end
	// answer only inside a command, never a stale low level
	assign ready_n = !(cmd_active && cmd_cnt_reg >= {1'b0, ready_delay});

endmodule : ext_mem_partner

// ===== tb/tb_top.sv
// Purpose: self-checking bench of chip select and ALE control
// Assumes: model below mirrors window and config writes
// Notes:   ready-ended cycles are checked by bounds, not exact length
`timescale 1ns/10ps
module tb_top;
	import ext_bus_cs_pkg::*;
	logic sys_clk, rstn, single_chip, bus_hold_ack, acc_start, acc_write;
	logic acc_internal, ready_n, acc_busy, acc_done, ale, read_strobe;
	logic write_low_strobe, write_high_strobe;
	logic [1:0] cs_count_select, acc_be;
	logic [3:0] rdy_dly;
	logic [N_CS-1:0] cfg_we, cs_open_drain, chip_select_n, chip_select_oe_n;
	logic [N_CS-1:0] chip_select_pullup, cs_lines_active;
	logic [N_WIN-1:0] win_we;
	logic [CFG_W-1:0] cfg_wdata;
	logic [WIN_W-1:0] win_wdata;
	logic [ADDR_W-1:0] acc_addr;
	logic [2:0] cur_window;
	int fails, n_compared, last_n, last_nr;
	int m_rd[5], m_wr[5], m_s[5], m_t[5], m_d[5], m_ws[5], m_rdy[5], m_en[5];
	int m_low;

	ext_bus_chip_select_ale_ctrl i_ext_bus_chip_select_ale_ctrl (
		.sys_clk(sys_clk), .rstn(rstn), .cs_count_select(cs_count_select),
		.single_chip(single_chip), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
		.win_we(win_we), .win_wdata(win_wdata),
		.cs_open_drain(cs_open_drain), .bus_hold_ack(bus_hold_ack),
		.acc_start(acc_start), .acc_addr(acc_addr), .acc_write(acc_write),
		.acc_be(acc_be), .acc_internal(acc_internal), .ready_n(ready_n),
		.acc_busy(acc_busy), .acc_done(acc_done), .ale(ale),
		.read_strobe(read_strobe), .write_low_strobe(write_low_strobe),
		.write_high_strobe(write_high_strobe),
		.chip_select_n(chip_select_n), .chip_select_oe_n(chip_select_oe_n),
		.chip_select_pullup(chip_select_pullup),
		.cs_lines_active(cs_lines_active), .cur_window(cur_window));
	ext_mem_partner i_ext_mem_partner (.sys_clk(sys_clk), .rstn(rstn),
		.cmd_active(read_strobe | write_low_strobe | write_high_strobe),
		.ready_delay(rdy_dly), .ready_n(ready_n));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic cmp_int(input string nm, input int e, input int s);
		n_compared++;
		if (e != s) begin
			fails++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, s);
		end
	endtask : cmp_int
	task automatic cmp_vec(input string nm, input logic [4:0] e,
		input logic [4:0] s);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, s);
		end
	endtask : cmp_vec
	function automatic logic [4:0] lines(input logic [1:0] s);
		return s == STRAP_FIVE ? LINES_FIVE : s == STRAP_NONE ? LINES_NONE :
			s == STRAP_TWO ? LINES_TWO : LINES_THREE;
	endfunction : lines
	// lowest enabled window hit wins, a miss falls back to line 0
	function automatic int win_of(input logic [23:0] a);
		for (int k = 1; k < 5; k++)
			if (m_en[k] != 0 && a[23:20] == 4'(k))
				return k;
		return 0;
	endfunction : win_of
	////////////////////////////////////////////////////////////////////
	// reset with a strap; a late strap change must not reach the mask
	task automatic do_reset(input logic [1:0] s);
		@(posedge sys_clk);
		#2 rstn = 1'b0;
		cs_count_select = s;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		cmp_vec("pull_rst", lines(s), chip_select_pullup);
		cmp_vec("oe_rst", 5'h1F, chip_select_oe_n);
		cmp_vec("cs_rst", 5'h1F, chip_select_n);
		@(posedge sys_clk);
		#2 rstn = 1'b1;
		repeat (2) @(posedge sys_clk);
		#2 cs_count_select = ~s;
		@(negedge sys_clk);
		cmp_vec("lines", lines(s), cs_lines_active);
		cmp_vec("oe_run", ~lines(s), chip_select_oe_n);
		cmp_vec("pull_run", 5'h00, chip_select_pullup);
		for (int k = 0; k < 5; k++) begin
			m_rd[k] = 0; m_wr[k] = 0; m_t[k] = 1; m_d[k] = 1;
			m_ws[k] = 15; m_rdy[k] = 0; m_en[k] = 0; m_s[k] = (k == 0);
		end
		m_low = 0;
	endtask : do_reset
	task automatic set_cfg(input int l, input int md, input int rdy);
		logic [CFG_W-1:0] w;
		w = '0;
		m_rd[l] = md & 1; m_wr[l] = md >> 1; m_rdy[l] = rdy;
		m_s[l] = $urandom_range(1, 0); m_t[l] = $urandom_range(1, 0);
		m_d[l] = $urandom_range(1, 0);
		m_ws[l] = rdy ? $urandom_range(7, 0) : $urandom_range(15, 1);
		w[CFG_RDEN_BIT] = m_rd[l][0]; w[CFG_WREN_BIT] = m_wr[l][0];
		w[CFG_ALE_BIT] = m_s[l][0]; w[CFG_TRI_BIT] = m_t[l][0];
		w[CFG_RWD_BIT] = m_d[l][0]; w[CFG_RDY_BIT] = 1'(rdy);
		w[CFG_WS_LSB +: CFG_WS_W] = m_ws[l][3:0];
		@(posedge sys_clk);
		#2 cfg_we = 5'(1 << l);
		cfg_wdata = w;
		@(posedge sys_clk);
		#2 cfg_we = '0;
	endtask : set_cfg
	// one access; strobes and ALE are watched every cycle, CS too on external command-mode windows
	task automatic access(input logic [23:0] a, input logic wr,
		input logic [1:0] be, input logic intl);
		int l, n, na, nr, nl, nh, bad, e, x, c, nb;
		l = win_of(a);
		x = intl | single_chip;
		n = 0; na = 0; nr = 0; nl = 0; nh = 0; bad = 0; nb = 0;
		@(posedge sys_clk);
		#2 acc_start = 1'b1;
		acc_addr = a; acc_write = wr; acc_be = be; acc_internal = intl;
		@(posedge sys_clk);
		#2 acc_start = 1'b0;
		do begin
			@(negedge sys_clk);
			n++;
			na += ale; nr += read_strobe;
			nb += acc_busy;
			nl += write_low_strobe; nh += write_high_strobe;
			c = (read_strobe & m_rd[l]) |
				((write_low_strobe | write_high_strobe) & m_wr[l]);
			if (x == 0 && (m_rd[l] | m_wr[l]) != 0 &&
				chip_select_n[l] !== 1'(~c))
				bad++;
		end while (acc_done !== 1'b1 && n < 600);
		last_n = n; last_nr = nr;
		if (n >= 600)
			cmp_int("done_seen", 1, 0);
		e = (2 + m_s[l]) + m_s[l] + m_d[l] + 2 * (1 + m_ws[l]) + 2 * m_t[l] + 1;
		if (m_rdy[l] == 0) begin
			cmp_int("cycle_len", x ? 1 : e, n);
			// busy covers the whole external cycle, never an internal one
			cmp_int("busy_len", x ? 0 : e - 1, nb);
			e = (x || wr) ? 0 : 2 * (1 + m_ws[l]);
			cmp_int("rd_len", e, nr);
			e = (x || !wr) ? 0 : 2 * (1 + m_ws[l]);
			cmp_int("wl_len", be[0] ? e : 0, nl);
			cmp_int("wh_len", be[1] ? e : 0, nh);
		end
		cmp_int("ale_len", x ? 0 : 2 + m_s[l], na);
		cmp_int("cs_follow", 0, bad);
		if (x == 0) begin
			m_low = (m_rd[l] | m_wr[l]) != 0 ? 0 : 1 << l;
			cmp_vec("window", 5'(l), {2'b00, cur_window});
		end
		cmp_vec("cs_after", ~5'(m_low), chip_select_n);
	endtask : access
	////////////////////////////////////////////////////////////////////
	initial begin
		fails = 0; n_compared = 0;
		void'($urandom(27395));
		rstn = 1'b0; cs_count_select = 2'h3;
		single_chip = 0; bus_hold_ack = 0; acc_start = 0; acc_write = 0;
		acc_internal = 0; acc_be = 2'h3; acc_addr = '0; cfg_we = '0;
		cfg_wdata = '0; win_we = '0; win_wdata = '0; rdy_dly = 4'h0;
		cs_open_drain = 5'($urandom);
		for (int s = 0; s < 4; s++)
			do_reset(2'(s));
		access(24'h012345, 1'b0, 2'h3, 1'b0);
		cmp_int("first_len", 40, last_n);
		for (int k = 1; k < 5; k++) begin
			@(posedge sys_clk);
			#2 win_we = 4'(1 << (k - 1));
			win_wdata = {1'b1, 12'hF00, 4'(k), 8'h00};
			@(posedge sys_clk);
			#2 win_we = '0;
			m_en[k] = 1;
			set_cfg(k, k - 1, 0);
		end
		set_cfg(0, $urandom_range(3, 1), 0);
		for (int k = 0; k < 5; k++)
			for (int w = 0; w < 2; w++)
				access({4'(k), 20'($urandom)}, 1'(w),
					2'($urandom_range(3, 1)), 1'b0);
		access(24'h2ABCDE, 1'b0, 2'h3, 1'b1);
		repeat (16)
			access({1'b0, 3'($urandom), 20'($urandom)}, 1'($urandom),
				2'($urandom_range(3, 1)), 1'b0);
		// ready-ended window with a slow partner
		set_cfg(3, 1, 1);
		rdy_dly = 4'($urandom_range(15, 4));
		access(24'h3F0000, 1'b0, 2'h3, 1'b0);
		cmp_int("rdy_wait", 1, int'(last_nr >= 2 * (1 + m_ws[3]) &&
			last_nr >= rdy_dly));
		@(posedge sys_clk);
		#2 single_chip = 1;
		access(24'h1F0000, 1'b0, 2'h3, 1'b0);
		@(posedge sys_clk);
		#2 single_chip = 0;
		bus_hold_ack = 1;
		cs_open_drain = 5'($urandom);
		@(negedge sys_clk);
		cmp_vec("oe_hold", 5'h1F, chip_select_oe_n);
		cmp_vec("pull_hold", 5'h1F & ~cs_open_drain, chip_select_pullup);
		@(posedge sys_clk);
		#2 bus_hold_ack = 0;
		close_out();
	end
	initial begin
		#600000;
		fails++;
		close_out();
	end

endmodule : tb_top
